/* File: core/dsc_ctrl_regs.sv */
`timescale 1ns/100ps
`include "dsc_defines.svh"


module dsc_ctrl_regs import dsc_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic latch_strobe,
  input wire dsc_loop_status_t aux_status,
  input wire dsc_loop_status_t main_status,
  input wire logic fast_acq_on,
  output dsc_loop_cfg_t aux_cfg,
  output dsc_loop_cfg_t main_cfg,
  output logic [3:0] multi_output_select,
  output logic aux_sleep,
  output logic main_sleep,
  output logic aux_counter_hold,
  output logic main_counter_hold,
  output logic multi_out,
  output logic multi_oe
);

  logic [`DSC_SYNC_W-1:0] pins_sync;
  logic s_clk;
  logic s_data;
  logic s_latch;
  dsc_loop_status_t aux_s;
  dsc_loop_status_t main_s;
  logic s_fast;

  // Every pin but clk_sys and rst_n passes two flops before use
  dsc_sync2 #(.W(`DSC_SYNC_W)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in({ser_clk, ser_data, latch_strobe, aux_status, main_status, fast_acq_on}),
    .sync_out(pins_sync)
  );

  assign {s_clk, s_data, s_latch, aux_s, main_s, s_fast} = pins_sync;

  // Field decode shared by both loops
  function automatic dsc_loop_cfg_t decode_loop(input logic [`DSC_DATA_W-1:0] ref_r,
                                                input logic [`DSC_DATA_W-1:0] fb_r);
    logic [`DSC_WORD_W-1:0] rw;
    logic [`DSC_WORD_W-1:0] fw;
    dsc_loop_cfg_t c;
    rw = {ref_r, 2'h0};
    fw = {fb_r, 2'h0};
    c.swallow_count = fw[`DSC_SWALLOW_MSB:`DSC_SWALLOW_LSB];
    c.binary_count = fw[`DSC_BINARY_MSB:`DSC_BINARY_LSB];
    c.reference_divide_value = rw[`DSC_REFDIV_MSB:`DSC_REFDIV_LSB];
    c.prescaler_select = fw[`DSC_PRESC_BIT];
    c.sleep_request = fw[`DSC_SLEEP_BIT];
    c.detector_polarity = rw[`DSC_POL_BIT];
    c.pump_gain_select = rw[`DSC_GAIN_BIT];
    c.pump_high_impedance = rw[`DSC_HIZ_BIT];
    return c;
  endfunction

  // Serial shift and register commit
  logic [`DSC_WORD_W-1:0] shift;
  logic [`DSC_WORD_W-1:0] next_shift;
  logic sclk_prev;
  logic latch_prev;
  logic [`DSC_DATA_W-1:0] aux_ref;
  logic [`DSC_DATA_W-1:0] aux_fb;
  logic [`DSC_DATA_W-1:0] main_ref;
  logic [`DSC_DATA_W-1:0] main_fb;
  logic [`DSC_DATA_W-1:0] next_aux_ref;
  logic [`DSC_DATA_W-1:0] next_aux_fb;
  logic [`DSC_DATA_W-1:0] next_main_ref;
  logic [`DSC_DATA_W-1:0] next_main_fb;
  logic latch_rise;

  assign latch_rise = s_latch && !latch_prev;
  // Shifting keeps running while a loop sleeps
  always_comb begin
    next_shift = shift;
    next_aux_ref = aux_ref;
    next_aux_fb = aux_fb;
    next_main_ref = main_ref;
    next_main_fb = main_fb;
    if (s_clk && !sclk_prev) begin
      next_shift = {shift[`DSC_WORD_W-2:0], s_data};
    end
    if (latch_rise) begin
      case (shift[`DSC_ADDR_W-1:0])
        `DSC_ADDR_AUX_REF: next_aux_ref = shift[`DSC_WORD_W-1:`DSC_ADDR_W];
        `DSC_ADDR_AUX_FB: next_aux_fb = shift[`DSC_WORD_W-1:`DSC_ADDR_W];
        `DSC_ADDR_MAIN_REF: next_main_ref = shift[`DSC_WORD_W-1:`DSC_ADDR_W];
        `DSC_ADDR_MAIN_FB: next_main_fb = shift[`DSC_WORD_W-1:`DSC_ADDR_W];
        default: next_aux_ref = aux_ref;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      shift <= '0;
      sclk_prev <= 1'b0;
      latch_prev <= 1'b0;
      aux_ref <= `DSC_REG_RESET;
      aux_fb <= `DSC_REG_RESET;
      main_ref <= `DSC_REG_RESET;
      main_fb <= `DSC_REG_RESET;
    end else begin
      shift <= next_shift;
      sclk_prev <= s_clk;
      latch_prev <= s_latch;
      aux_ref <= next_aux_ref;
      aux_fb <= next_aux_fb;
      main_ref <= next_main_ref;
      main_fb <= next_main_fb;
    end
  end

  // High impedance follows the register bit with no extra delay
  assign aux_cfg = decode_loop(aux_ref, aux_fb);
  assign main_cfg = decode_loop(main_ref, main_fb);
  assign multi_output_select = {main_ref[`DSC_OSEL_HI_BIT-`DSC_ADDR_W],
                                aux_ref[`DSC_OSEL_HI_BIT-`DSC_ADDR_W],
                                main_ref[`DSC_OSEL_LO_BIT-`DSC_ADDR_W],
                                aux_ref[`DSC_OSEL_LO_BIT-`DSC_ADDR_W]};

  // Power state per loop, index 0 aux and 1 main
  dsc_pwr_state_t pwr [2];
  dsc_pwr_state_t next_pwr [2];
  logic [1:0] req;
  logic [1:0] hiz;
  logic [1:0] pump_now;
  logic [1:0] pump_prev;
  logic [1:0] pump_fall;

  assign req = {main_cfg.sleep_request, aux_cfg.sleep_request};
  assign hiz = {main_cfg.pump_high_impedance, aux_cfg.pump_high_impedance};
  assign pump_now = {main_s.pump_active, aux_s.pump_active};
  assign pump_fall = pump_prev & ~pump_now;

  // A driving pump must finish its pulse, else loop filter charge is lost
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_pwr[i] = pwr[i];
      case (pwr[i])
        PWR_ACTIVE: begin
          if (req[i] && hiz[i]) begin
            next_pwr[i] = PWR_SLEEP;
          end else if (req[i]) begin
            next_pwr[i] = PWR_WAIT;
          end
        end
        PWR_WAIT: begin
          if (!req[i]) begin
            next_pwr[i] = PWR_ACTIVE;
          end else if (hiz[i] || pump_fall[i]) begin
            next_pwr[i] = PWR_SLEEP;
          end
        end
        PWR_SLEEP: begin
          if (!req[i]) begin
            next_pwr[i] = PWR_ACTIVE;
          end
        end
        default: next_pwr[i] = PWR_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pump_prev <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        pwr[i] <= PWR_ACTIVE;
      end
    end else begin
      pump_prev <= pump_now;
      for (int i = 0; i < 2; i++) begin
        pwr[i] <= next_pwr[i];
      end
    end
  end

  assign aux_sleep = (pwr[0] == PWR_SLEEP);
  assign main_sleep = (pwr[1] == PWR_SLEEP);

  // Multi-function pin and counter holds
  logic next_out;
  logic next_oe;
  logic next_aux_hold;
  logic next_main_hold;

  // Open-drain choices keep the level low and switch only the enable
  always_comb begin
    next_out = 1'b0;
    next_oe = 1'b1;
    next_aux_hold = aux_sleep;
    next_main_hold = main_sleep;
    case (multi_output_select)
      `DSC_OSEL_LOW: next_oe = 1'b1;
      `DSC_OSEL_AUX_REF_A, `DSC_OSEL_AUX_REF_B: next_out = aux_s.ref_div;
      `DSC_OSEL_AUX_FB_A, `DSC_OSEL_AUX_FB_B: next_out = aux_s.fb_div;
      `DSC_OSEL_MAIN_REF_A, `DSC_OSEL_MAIN_REF_B: next_out = main_s.ref_div;
      `DSC_OSEL_MAIN_FB_A, `DSC_OSEL_MAIN_FB_B: next_out = main_s.fb_div;
      `DSC_OSEL_FAST_ACQ: next_oe = s_fast;
      `DSC_OSEL_AUX_LOCK: next_oe = aux_s.pump_active;
      `DSC_OSEL_MAIN_LOCK: next_oe = main_s.pump_active;
      `DSC_OSEL_BOTH_LOCK: next_oe = aux_s.pump_active || main_s.pump_active;
      `DSC_OSEL_RST_AUX: next_aux_hold = 1'b1;
      `DSC_OSEL_RST_MAIN: next_main_hold = 1'b1;
      `DSC_OSEL_RST_ALL: begin
        next_aux_hold = 1'b1;
        next_main_hold = 1'b1;
      end
      default: next_oe = 1'b1;
    endcase
  end

  // Both dividers of a loop share one hold, so they release together
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      multi_out <= 1'b0;
      multi_oe <= 1'b1;
      aux_counter_hold <= 1'b0;
      main_counter_hold <= 1'b0;
    end else begin
      multi_out <= next_out;
      multi_oe <= next_oe;
      aux_counter_hold <= next_aux_hold;
      main_counter_hold <= next_main_hold;
    end
  end

  latch_commit_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (latch_rise && shift[1:0] == `DSC_ADDR_MAIN_FB) |=> (main_fb == $past(shift[21:2])))
    else $error("main feedback not loaded on latch");
  shift_in_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (s_clk && !sclk_prev) |=> (shift[0] == $past(s_data) && shift[21:1] == $past(shift[20:0])))
    else $error("serial bit not shifted in");
  swallow_field_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (latch_rise && shift[1:0] == `DSC_ADDR_AUX_FB) |=> (aux_cfg.swallow_count == $past(shift[6:2])))
    else $error("aux swallow count wrong");
  hiz_follow_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (latch_rise && shift[1:0] == `DSC_ADDR_AUX_REF)
      |=> (aux_cfg.pump_high_impedance == $past(shift[19])))
    else $error("aux high impedance not applied");
  sync_sleep_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (pwr[0] != PWR_SLEEP && req[0] && !hiz[0] && !pump_fall[0]) |=> (pwr[0] != PWR_SLEEP))
    else $error("aux slept before pump pulse ended");
  async_sleep_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (req[1] && hiz[1]) |=> main_sleep)
    else $error("main did not sleep at once");
  pin_low_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (multi_output_select == `DSC_OSEL_LOW) |=> (multi_oe && !multi_out))
    else $error("pin not driven low");
  pin_route_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (multi_output_select == `DSC_OSEL_AUX_FB_B) |=> (multi_oe && multi_out == $past(aux_s.fb_div)))
    else $error("aux feedback not routed");
  lock_drain_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (multi_output_select == `DSC_OSEL_MAIN_LOCK)
      |=> (!multi_out && multi_oe == $past(main_s.pump_active)))
    else $error("main lock output wrong");
  hold_all_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (multi_output_select == `DSC_OSEL_RST_ALL)
      |=> (aux_counter_hold && main_counter_hold && multi_oe && !multi_out))
    else $error("counters not held");

endmodule

/* File: include/dsc_defines.svh */
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH

// Serial word layout: 20 data bits above 2 address bits
`define DSC_WORD_W 22
`define DSC_DATA_W 20
`define DSC_ADDR_W 2
`define DSC_REG_RESET 20'h00000

// Register addresses carried in the word's low bits
`define DSC_ADDR_AUX_REF 2'h0
`define DSC_ADDR_AUX_FB 2'h1
`define DSC_ADDR_MAIN_REF 2'h2
`define DSC_ADDR_MAIN_FB 2'h3

// Field positions, counted in serial word bit positions
`define DSC_SWALLOW_LSB 2
`define DSC_SWALLOW_MSB 6
`define DSC_BINARY_LSB 7
`define DSC_BINARY_MSB 19
`define DSC_REFDIV_LSB 2
`define DSC_REFDIV_MSB 16
`define DSC_POL_BIT 17
`define DSC_GAIN_BIT 18
`define DSC_HIZ_BIT 19
`define DSC_PRESC_BIT 20
`define DSC_SLEEP_BIT 21
`define DSC_OSEL_LO_BIT 20
`define DSC_OSEL_HI_BIT 21

// Multi-function pin selections
`define DSC_OSEL_LOW 4'h0
`define DSC_OSEL_AUX_REF_A 4'h1
`define DSC_OSEL_MAIN_REF_A 4'h2
`define DSC_OSEL_FAST_ACQ 4'h3
`define DSC_OSEL_AUX_LOCK 4'h4
`define DSC_OSEL_AUX_FB_A 4'h5
`define DSC_OSEL_MAIN_FB_A 4'h6
`define DSC_OSEL_RST_AUX 4'h7
`define DSC_OSEL_MAIN_LOCK 4'h8
`define DSC_OSEL_AUX_REF_B 4'h9
`define DSC_OSEL_MAIN_REF_B 4'hA
`define DSC_OSEL_RST_MAIN 4'hB
`define DSC_OSEL_BOTH_LOCK 4'hC
`define DSC_OSEL_AUX_FB_B 4'hD
`define DSC_OSEL_MAIN_FB_B 4'hE
`define DSC_OSEL_RST_ALL 4'hF

// Width of the pin synchroniser bank
`define DSC_SYNC_W 10

`endif

/* File: include/dsc_pkg.sv */
package dsc_pkg;

  // Decoded settings of one synthesizer loop
  typedef struct packed {
    logic [4:0] swallow_count;
    logic [12:0] binary_count;
    logic [14:0] reference_divide_value;
    logic prescaler_select;
    logic detector_polarity;
    logic pump_gain_select;
    logic pump_high_impedance;
    logic sleep_request;
  } dsc_loop_cfg_t;

  // Live signals coming back from one loop
  typedef struct packed {
    logic ref_div;
    logic fb_div;
    logic pump_active;
  } dsc_loop_status_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_WAIT,
    PWR_SLEEP
  } dsc_pwr_state_t;

endpackage

/* File: core/dsc_sync2.sv */
`timescale 1ns/100ps
`include "dsc_defines.svh"

module dsc_sync2 import dsc_pkg::*; #(
  parameter int W = `DSC_SYNC_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

/* File: tb/dsc_host_model.sv */
`timescale 1ns/100ps

// Host end of the three-wire link; serial clock stands low between frames
module dsc_host_model (
  output logic ser_clk,
  output logic ser_data,
  output logic latch_strobe
);
  initial begin
    ser_clk = 1'h0;
    ser_data = 1'h0;
    latch_strobe = 1'h0;
  end

  // MSB first, then a latch rise; data flips once used so no stale level lingers
  task automatic send(input logic [21:0] w);
    #3;
    for (int i = 21; i >= 0; i--) begin
      ser_data = w[i];
      #16 ser_clk = 1'h1;
      #32 ser_clk = 1'h0;
      ser_data = ~w[i];
      #16;
    end
    #32 latch_strobe = 1'h1;
    #64 latch_strobe = 1'h0;
    #32;
  endtask
endmodule

/* File: tb/dsc_ctrl_regs_test.sv */
`timescale 1ns/100ps

module dsc_ctrl_regs_test import dsc_pkg::*; ;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic ser_clk;
  logic ser_data;
  logic latch_strobe;
  dsc_loop_status_t aux_status = '0;
  dsc_loop_status_t main_status = '0;
  logic fast_acq_on = 1'h0;
  dsc_loop_cfg_t aux_cfg;
  dsc_loop_cfg_t main_cfg;
  logic [3:0] multi_output_select;
  logic aux_sleep;
  logic main_sleep;
  logic aux_counter_hold;
  logic main_counter_hold;
  logic multi_out;
  logic multi_oe;
  int err_total = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h8;

  always #4 clk_sys = ~clk_sys;

  dsc_host_model i_host (
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .latch_strobe(latch_strobe)
  );

  dsc_ctrl_regs i_dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .latch_strobe(latch_strobe),
    .aux_status(aux_status),
    .main_status(main_status),
    .fast_acq_on(fast_acq_on),
    .aux_cfg(aux_cfg),
    .main_cfg(main_cfg),
    .multi_output_select(multi_output_select),
    .aux_sleep(aux_sleep),
    .main_sleep(main_sleep),
    .aux_counter_hold(aux_counter_hold),
    .main_counter_hold(main_counter_hold),
    .multi_out(multi_out),
    .multi_oe(multi_oe)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected {level, enable}; open-drain picks pull low only while enabled
  function automatic logic [1:0] pin_exp(input logic [3:0] s, input dsc_loop_status_t a,
                                         input dsc_loop_status_t m, input logic f);
    case (s)
      4'h1, 4'h9: return {a.ref_div, 1'h1};
      4'h5, 4'hD: return {a.fb_div, 1'h1};
      4'h2, 4'hA: return {m.ref_div, 1'h1};
      4'h6, 4'hE: return {m.fb_div, 1'h1};
      4'h3: return {1'h0, f};
      4'h4: return {1'h0, a.pump_active};
      4'h8: return {1'h0, m.pump_active};
      4'hC: return {1'h0, a.pump_active | m.pump_active};
      default: return 2'h1;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [37:0] exp, input logic [37:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Sample a little after the edge so registered outputs have landed
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wait_sleep(input bit lp, input logic exp, input int lim);
    int n;
    n = 0;
    while ((lp ? main_sleep : aux_sleep) !== exp && n < lim) begin
      settle(1);
      n++;
    end
    chk("sleep", exp, lp ? main_sleep : aux_sleep);
    if ((lp ? main_sleep : aux_sleep) !== exp)
      complete_run();
  endtask

  task automatic set_pump(input logic v);
    @(posedge clk_sys);
    aux_status <= {2'h0, v};
    main_status <= {2'h0, v};
  endtask

  initial begin
    #400000;
    err_total++;
    complete_run();
  end

  initial begin
    logic [21:0] w;
    logic [31:0] r;
    dsc_loop_cfg_t c;
    bit lp;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'h1;
    settle(4);
    // Feedback words, counts at both ends of their ranges then random
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      lp = k[0];
      w[21:20] = {1'h0, r[20]};
      w[19:7] = (k == 0) ? 13'h3 : (k == 1) ? 13'h1FFF : 13'(3 + r % 8189);
      w[6:0] = {(k == 0) ? 5'h0 : (k == 1) ? 5'h1F : r[4:0], lp, 1'h1};
      i_host.send(w);
      settle(8);
      c = lp ? main_cfg : aux_cfg;
      chk("fb", w[21:2], {c.sleep_request, c.prescaler_select, c.binary_count,
          c.swallow_count});
    end
    // Reference words
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      lp = k[0];
      w = {2'h0, r[7:5], (k < 2) ? 15'h2 : (k < 4) ? 15'h7FFF : 15'(2 + r % 32766), lp, 1'h0};
      i_host.send(w);
      settle(8);
      c = lp ? main_cfg : aux_cfg;
      chk("ref", w[19:2], {c.pump_high_impedance, c.pump_gain_select, c.detector_polarity,
          c.reference_divide_value});
    end
    // Every pin selection against random live status
    for (int s = 0; s < 16; s++) begin
      i_host.send({s[2], s[0], 3'h0, 15'h2, 2'h0});
      i_host.send({s[3], s[1], 3'h0, 15'h2, 2'h2});
      for (int j = 0; j < 3; j++) begin
        r = rnd();
        @(posedge clk_sys);
        aux_status <= r[2:0];
        main_status <= r[5:3];
        fast_acq_on <= r[6];
        settle(6);
        chk("select", s[3:0], multi_output_select);
        chk("pin", pin_exp(s[3:0], aux_status, main_status, fast_acq_on),
            {multi_out, multi_oe});
        chk("hold", {s[3:0] == 4'h7 || s[3:0] == 4'hF, s[3:0] == 4'hB || s[3:0] == 4'hF},
            {aux_counter_hold, main_counter_hold});
      end
    end
    // Sleep entry, immediate with pump set to high impedance, deferred while a pulse lasts
    for (int k = 0; k < 2; k++) begin
      lp = k[0];
      i_host.send({3'h1, 2'h0, 15'h2, lp, 1'h0});
      i_host.send({2'h2, 13'h3, 5'h0, lp, 1'h1});
      wait_sleep(lp, 1'h1, 8);
      chk("sleep hold", 1'h1, lp ? main_counter_hold : aux_counter_hold);
      i_host.send({2'h0, 13'h3, 5'h0, lp, 1'h1});
      wait_sleep(lp, 1'h0, 8);
      set_pump(1'h1);
      i_host.send({3'h0, 2'h0, 15'h2, lp, 1'h0});
      i_host.send({2'h2, 13'h3, 5'h0, lp, 1'h1});
      settle(10);
      chk("sleep early", 1'h0, lp ? main_sleep : aux_sleep);
      set_pump(1'h0);
      wait_sleep(lp, 1'h1, 8);
      i_host.send({2'h0, 13'h3, 5'h0, lp, 1'h1});
      wait_sleep(lp, 1'h0, 8);
    end
    complete_run();
  end
endmodule
